// [core/wfct_pkg.sv]
/*
 * Shared constants and types for the wake filter and cyclic timer block:
 * register indices, field layouts, codes, time figures and bus encodings.
 * Assumes a single 40 MHz clock and an AHB-Lite register port.
 */
package wfct_pkg;

	// ==========================================================
	// Clock and time base
	localparam int CLK_HZ = 40_000_000;
	localparam int US_PER_S = 1_000_000;
	localparam int TICK_CYC_DEF = CLK_HZ / US_PER_S; // Cycles per microsecond
	localparam int MS_US = 1000;
	localparam int STEP_US = 100; // Timer resolution
	localparam int FILT_SHORT_US = 16;
	localparam int FILT_LONG_US = 64;

	// On-time figures in microseconds, period figures in milliseconds
	localparam int ON_0P1_US = 100;
	localparam int ON_0P3_US = 300;
	localparam int ON_1P0_US = 1000;
	localparam int ON_10_US = 10000;
	localparam int ON_20_US = 20000;
	localparam int PER_10_MS = 10;
	localparam int PER_20_MS = 20;
	localparam int PER_50_MS = 50;
	localparam int PER_100_MS = 100;
	localparam int PER_200_MS = 200;
	localparam int PER_1S_MS = 1000;
	localparam int PER_2S_MS = 2000;
	localparam int STEP_W = 15;
	localparam int FCNT_W = 7;

	// ==========================================================
	// Register map: printed offsets are word indices
	localparam logic [7:0] FILT_IDX = 8'h09;
	localparam logic [7:0] TMR_IDX = 8'h0C;
	localparam int TMR_ON_LSB = 4;
	localparam int TMR_PER_LSB = 0;
	localparam int NUM_IN = 3;
	localparam logic [5:0] FILT_RST = 6'h00;

	// ==========================================================
	// Codes
	localparam logic [1:0] FLT_STATIC16 = 2'h0;
	localparam logic [1:0] FLT_STATIC64 = 2'h1;
	localparam logic [1:0] FLT_CYC_T1 = 2'h2;
	localparam logic [1:0] FLT_CYC_T2 = 2'h3;
	localparam logic [2:0] ON_STOP_LO = 3'h0;
	localparam logic [2:0] ON_STOP_HI = 3'h6;
	localparam logic [2:0] ON_RSVD = 3'h7;
	localparam logic [2:0] PER_RSVD = 3'h7;

	// ==========================================================
	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef struct packed {
		logic [1:0] in3;
		logic [1:0] in2;
		logic [1:0] in1;
	} wfct_filt_s;

	typedef struct packed {
		logic [2:0] on;
		logic [2:0] per;
	} wfct_tmr_s;

	typedef enum logic [3:0] {
		T_LOW = 4'h1,
		T_HIGH = 4'h2,
		T_ON = 4'h4,
		T_OFF = 4'h8
	} wfct_state_e;

endpackage : wfct_pkg

// [core/wfct_top.sv]
/*
 * Wake input filter selection and first cyclic timer, with an AHB-Lite
 * register slave. Three wake pins are filtered statically or sampled at
 * the end of a timer on-time. Assumes restart, soft reset and switch
 * clear events come from logic on MCLK; wake pins are asynchronous.
 */
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps

module wfct_top
	import wfct_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYC_DEF
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Device mode and switch events
	input wire logic SOFT_RESET,
	input wire logic RESTART_ENTRY,
	input wire logic RESTART_MODE,
	input wire logic HS_CLEARED,
	input wire logic TIMER_ONE_ASSIGNED,
	input wire logic TIMER_ONE_WAKE_ENABLE,
	input wire logic TIMER_TWO_ON,
	// Wake pins and results
	input wire logic [NUM_IN-1:0] WAKE_PIN,
	output logic [NUM_IN-1:0] WAKE_LEVEL,
	output logic [NUM_IN-1:0] WAKE_EVENT,
	// Timer one
	output logic HIGH_SIDE_OUTPUT,
	output logic CYCLIC_WAKE
);

	// ==========================================================
	// Elaboration checks
	// The microsecond counter is sixteen bits wide
	if (TICK_CYC < 1 || TICK_CYC > 65536) begin : g_bad_tick
		$error("TICK_CYC must be between 1 and 65536");
	end

	// ==========================================================
	// Decoding helpers
	function automatic logic [STEP_W-1:0] on_steps(input logic [2:0] code);
		case (code)
			3'h1: on_steps = STEP_W'(ON_0P1_US / STEP_US);
			3'h2: on_steps = STEP_W'(ON_0P3_US / STEP_US);
			3'h3: on_steps = STEP_W'(ON_1P0_US / STEP_US);
			3'h4: on_steps = STEP_W'(ON_10_US / STEP_US);
			3'h5: on_steps = STEP_W'(ON_20_US / STEP_US);
			default: on_steps = STEP_W'(1);
		endcase
	endfunction : on_steps

	function automatic logic [STEP_W-1:0] per_steps(input logic [2:0] code);
		case (code)
			3'h0: per_steps = STEP_W'(PER_10_MS * MS_US / STEP_US);
			3'h1: per_steps = STEP_W'(PER_20_MS * MS_US / STEP_US);
			3'h2: per_steps = STEP_W'(PER_50_MS * MS_US / STEP_US);
			3'h3: per_steps = STEP_W'(PER_100_MS * MS_US / STEP_US);
			3'h4: per_steps = STEP_W'(PER_200_MS * MS_US / STEP_US);
			3'h5: per_steps = STEP_W'(PER_1S_MS * MS_US / STEP_US);
			3'h6: per_steps = STEP_W'(PER_2S_MS * MS_US / STEP_US);
			default: per_steps = STEP_W'(1);
		endcase
	endfunction : per_steps

	// True for an on-time code that lets the timer run
	function automatic logic is_running(input logic [2:0] code);
		is_running = (code != ON_STOP_LO) && (code != ON_STOP_HI) && (code != ON_RSVD);
	endfunction : is_running

	function automatic logic is_cyclic(input logic [1:0] code);
		is_cyclic = (code == FLT_CYC_T1) || (code == FLT_CYC_T2);
	endfunction : is_cyclic

	// ==========================================================
	// AHB-Lite slave
	logic wr_pend_r;
	logic [7:0] wr_idx_r;
	logic [31:0] rdata_r;
	logic addr_ok;
	logic acc;
	logic wr_filt;
	logic wr_tmr;
	wfct_filt_s filt_r;
	wfct_filt_s filt_nxt;
	wfct_tmr_s tmr_r;
	wfct_tmr_s tmr_nxt;
	logic tmr_clr;
	logic any_cyc;

	assign acc = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
	assign addr_ok = (HADDR[31:10] == 22'h00_0000) && (HADDR[1:0] == 2'h0);
	assign wr_filt = wr_pend_r && (wr_idx_r == FILT_IDX);
	assign wr_tmr = wr_pend_r && (wr_idx_r == TMR_IDX);
	// Zero wait states, never an error
	assign HREADYOUT = 1'b1;
	assign HRESP = HRESP_OKAY;
	assign HRDATA = rdata_r;

	// Address phase capture for writes
	always_ff @(posedge MCLK) begin
		if (RST) begin
			wr_pend_r <= 1'b0;
			wr_idx_r <= 8'h00;
		end else begin
			wr_pend_r <= acc && HWRITE && addr_ok;
			wr_idx_r <= HADDR[9:2];
		end
	end

	// Read data taken from next values so a write just ahead is seen
	always_ff @(posedge MCLK) begin
		if (RST) begin
			rdata_r <= 32'h0000_0000;
		end else if (acc && !HWRITE) begin
			rdata_r <= 32'h0000_0000; // Unmapped reads return zero
			if (addr_ok && HADDR[9:2] == FILT_IDX) begin
				rdata_r[5:0] <= filt_nxt;
			end else if (addr_ok && HADDR[9:2] == TMR_IDX) begin
				rdata_r[TMR_ON_LSB +: 3] <= tmr_nxt.on;
				rdata_r[TMR_PER_LSB +: 3] <= tmr_nxt.per;
			end
		end
	end

	// ==========================================================
	// Configuration registers
	assign any_cyc = is_cyclic(filt_r.in1) || is_cyclic(filt_r.in2) || is_cyclic(filt_r.in3);
	// Hardware clear beats a software write in the same cycle, safer side
	assign tmr_clr = SOFT_RESET || RESTART_ENTRY
		|| (HS_CLEARED && RESTART_MODE && any_cyc);

	// Next register values; only the defined bits are ever stored
	always_comb begin
		filt_nxt = filt_r;
		tmr_nxt = tmr_r;
		if (wr_filt) begin
			filt_nxt = HWDATA[5:0];
		end
		if (SOFT_RESET) begin
			filt_nxt = FILT_RST;
		end
		if (wr_tmr) begin
			tmr_nxt.on = HWDATA[TMR_ON_LSB +: 3];
			tmr_nxt.per = HWDATA[TMR_PER_LSB +: 3];
		end
		if (tmr_clr) begin
			tmr_nxt = '0;
		end
	end

	// Restart entry leaves the filter bits as they are
	always_ff @(posedge MCLK) begin
		if (RST) begin
			filt_r <= FILT_RST;
			tmr_r <= '0;
		end else begin
			filt_r <= filt_nxt;
			tmr_r <= tmr_nxt;
		end
	end

	// ==========================================================
	// Microsecond time base
	logic [15:0] us_cnt_r;
	logic us_tick;

	assign us_tick = (us_cnt_r == 16'(TICK_CYC - 1));

	always_ff @(posedge MCLK) begin
		if (RST || us_tick) begin
			us_cnt_r <= 16'h0000;
		end else begin
			us_cnt_r <= us_cnt_r + 16'h0001;
		end
	end

	// ==========================================================
	// Timer one
	wfct_state_e state_r;
	wfct_state_e state_nxt;
	logic [6:0] t_us_r;
	logic [STEP_W-1:0] t_cnt_r;
	logic start_r;
	logic run_ok;
	logic step;
	logic sample;
	logic expire;

	assign run_ok = TIMER_ONE_ASSIGNED && is_running(tmr_r.on) && (tmr_r.per != PER_RSVD);
	assign step = us_tick && (t_us_r == 7'(STEP_US - 1));
	assign sample = (state_r == T_ON) && step && (t_cnt_r == on_steps(tmr_r.on) - 1'b1);
	assign expire = (state_r == T_OFF) && step && (t_cnt_r >= per_steps(tmr_r.per) - 1'b1);

	// A write of a running code restarts the cycle
	always_ff @(posedge MCLK) begin
		if (RST) begin
			start_r <= 1'b0;
		end else begin
			start_r <= wr_tmr && !tmr_clr && is_running(HWDATA[TMR_ON_LSB +: 3]);
		end
	end

	// Phase sequence
	always_comb begin
		state_nxt = state_r;
		if (!run_ok) begin
			state_nxt = (tmr_r.on == ON_STOP_HI) ? T_HIGH : T_LOW;
		end else begin
			case (state_r)
				T_LOW, T_HIGH: state_nxt = T_ON;
				T_ON: if (sample) begin
					state_nxt = T_OFF;
				end
				T_OFF: if (expire) begin
					state_nxt = T_ON;
				end
				default: state_nxt = T_LOW;
			endcase
			if (start_r) begin
				state_nxt = T_ON;
			end
		end
	end

	// Period counters; count runs from on-time start to period end
	always_ff @(posedge MCLK) begin
		// Held while stopped too, so a start from a stop code gets a full first step
		if (RST || state_r == T_LOW || state_r == T_HIGH || state_nxt == T_LOW
			|| state_nxt == T_HIGH || start_r || expire) begin
			t_us_r <= 7'h00;
			t_cnt_r <= '0;
		end else if (us_tick) begin
			t_us_r <= step ? 7'h00 : t_us_r + 7'h01;
			if (step) begin
				t_cnt_r <= t_cnt_r + 1'b1;
			end
		end
	end

	// Wake pulse is independent of the sensing use of the same timer
	always_ff @(posedge MCLK) begin
		if (RST) begin
			state_r <= T_LOW;
			HIGH_SIDE_OUTPUT <= 1'b0;
			CYCLIC_WAKE <= 1'b0;
		end else begin
			state_r <= state_nxt;
			HIGH_SIDE_OUTPUT <= (state_nxt == T_ON) || (state_nxt == T_HIGH);
			CYCLIC_WAKE <= expire && TIMER_ONE_WAKE_ENABLE;
		end
	end

	// ==========================================================
	// Wake input filters
	logic t2_on_d_r;
	logic [1:0] codes [NUM_IN];

	assign codes[0] = filt_r.in1;
	assign codes[1] = filt_r.in2;
	assign codes[2] = filt_r.in3;

	always_ff @(posedge MCLK) begin
		if (RST) begin
			t2_on_d_r <= 1'b0;
		end else begin
			t2_on_d_r <= TIMER_TWO_ON;
		end
	end

	for (genvar i = 0; i < NUM_IN; i++) begin : g_in
		logic sync1_r;
		logic sync2_r;
		logic [FCNT_W-1:0] cnt_r;
		logic win;
		logic smp;
		logic upd;
		logic [FCNT_W-1:0] limit;

		// Cyclic inputs only count while their switch powers them
		assign win = (codes[i] == FLT_CYC_T1) ? (state_r == T_ON) : TIMER_TWO_ON;
		assign smp = (codes[i] == FLT_CYC_T1) ? sample : (t2_on_d_r && !TIMER_TWO_ON);
		assign limit = (codes[i] == FLT_STATIC64) ? FCNT_W'(FILT_LONG_US)
			: FCNT_W'(FILT_SHORT_US);
		assign upd = is_cyclic(codes[i]) ? (smp && cnt_r >= limit)
			: (cnt_r >= limit);

		// Two-stage synchroniser, first stage read only by the second
		always_ff @(posedge MCLK) begin
			if (RST) begin
				sync1_r <= 1'b0;
				sync2_r <= 1'b0;
			end else begin
				sync1_r <= WAKE_PIN[i];
				sync2_r <= sync1_r;
			end
		end

		// Stability counter saturates at the long filter time
		always_ff @(posedge MCLK) begin
			if (RST || sync2_r == WAKE_LEVEL[i] || upd
				|| (is_cyclic(codes[i]) && !win)) begin
				cnt_r <= '0;
			end else if (us_tick && cnt_r < FCNT_W'(FILT_LONG_US)) begin
				cnt_r <= cnt_r + 1'b1;
			end
		end

		always_ff @(posedge MCLK) begin
			if (RST) begin
				WAKE_LEVEL[i] <= 1'b0;
				WAKE_EVENT[i] <= 1'b0;
			end else begin
				WAKE_EVENT[i] <= upd;
				if (upd) begin
					WAKE_LEVEL[i] <= sync2_r;
				end
			end
		end

		property p_static_len;
			@(posedge MCLK) disable iff (RST)
			$changed(WAKE_LEVEL[i]) && !$past(is_cyclic(codes[i]))
			|-> $past(cnt_r) >= $past(limit);
		endproperty
		a_static_len: assert property (p_static_len) else $error("static filter too short");

		property p_cyc_on_sample;
			@(posedge MCLK) disable iff (RST)
			$changed(WAKE_LEVEL[i]) && $past(is_cyclic(codes[i])) |-> $past(smp);
		endproperty
		a_cyc_on_sample: assert property (p_cyc_on_sample) else $error("cyclic update off sample");
	end

	// ==========================================================
	// Checks
	sequence s_rd(logic [7:0] idx);
		acc && !HWRITE && addr_ok && HADDR[9:2] == idx;
	endsequence

	property p_filt_rsvd;
		@(posedge MCLK) disable iff (RST)
		s_rd(FILT_IDX) |=> HRDATA[31:6] == 26'h000_0000;
	endproperty
	a_filt_rsvd: assert property (p_filt_rsvd) else $error("filter reserved bits set");

	property p_tmr_rsvd;
		@(posedge MCLK) disable iff (RST)
		s_rd(TMR_IDX) |=> HRDATA[31:7] == 25'h000_0000 && !HRDATA[3];
	endproperty
	a_tmr_rsvd: assert property (p_tmr_rsvd) else $error("timer reserved bits set");

	property p_stop_out;
		@(posedge MCLK) disable iff (RST)
		!run_ok |=> HIGH_SIDE_OUTPUT == ($past(tmr_r.on) == ON_STOP_HI);
	endproperty
	a_stop_out: assert property (p_stop_out) else $error("stopped output level wrong");

	sequence s_start;
		start_r && run_ok;
	endsequence

	property p_start;
		@(posedge MCLK) disable iff (RST)
		s_start |=> HIGH_SIDE_OUTPUT && state_r == T_ON && t_cnt_r == '0;
	endproperty
	a_start: assert property (p_start) else $error("timer did not start");

	property p_restart_tmr;
		@(posedge MCLK) disable iff (RST)
		RESTART_ENTRY || (HS_CLEARED && RESTART_MODE && any_cyc) |=> tmr_r == '0;
	endproperty
	a_restart_tmr: assert property (p_restart_tmr) else $error("timer not cleared");

	property p_restart_filt;
		@(posedge MCLK) disable iff (RST)
		RESTART_ENTRY && !SOFT_RESET && !wr_filt |=> filt_r == $past(filt_r);
	endproperty
	a_restart_filt: assert property (p_restart_filt) else $error("filter lost on restart");

	property p_soft;
		@(posedge MCLK) disable iff (RST)
		SOFT_RESET |=> filt_r == FILT_RST && tmr_r == '0;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset missed");

	property p_wake;
		@(posedge MCLK) disable iff (RST)
		expire |=> CYCLIC_WAKE == $past(TIMER_ONE_WAKE_ENABLE);
	endproperty
	a_wake: assert property (p_wake) else $error("wake gating wrong");

	property p_phase;
		@(posedge MCLK) disable iff (RST)
		(sample && run_ok && !start_r |=> !HIGH_SIDE_OUTPUT)
		and (expire && run_ok |=> HIGH_SIDE_OUTPUT);
	endproperty
	a_phase: assert property (p_phase) else $error("phase output wrong");

endmodule : wfct_top

// [verification/wfct_switch_model.sv]
/*
 * Model of the external wake switches on the three wake inputs.
 * Assumes each pin has a pull-down and that a switch is either fed
 * from the timer one high-side output or from the battery supply.
 */
`timescale 1ns/1ps

module wfct_switch_model (
	// Supply from the high-side output
	input wire logic hs_out,
	// Contact state and feed choice, bit0 is input one
	input wire logic [2:0] hs_fed,
	input wire logic [2:0] closed,
	// Wake pins
	output logic [2:0] pin
);
	// ==========================================================
	// Contacts
	// An open contact leaves the pin on its pull-down, so it never
	// shows a stale high; a fed contact is live only while the switch is on
	assign pin = closed & ((hs_fed & {3{hs_out}}) | ~hs_fed);
endmodule : wfct_switch_model

// [verification/wake_filter_cyclic_timer_bench.sv]
/*
 * Self-checking bench for the wake filter and cyclic timer block.
 * Assumes TICK_CYC of 1, so one microsecond lasts one clock.
 */
`timescale 1ns/1ps

module wake_filter_cyclic_timer_bench;
	import wfct_pkg::*;
	// ==========================================================
	// Signals
	logic MCLK = 0, RST = 1, HSEL = 0, HWRITE = 0;
	logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, rd;
	logic [1:0] HTRANS = 0;
	logic [2:0] HSIZE = 3'h2, WAKE_PIN, WAKE_LEVEL, WAKE_EVENT, sw_closed = 0, sw_fed = 0;
	logic HREADYOUT, HRESP, SOFT_RESET = 0, RESTART_ENTRY = 0, RESTART_MODE = 0;
	logic HS_CLEARED = 0, TIMER_ONE_ASSIGNED = 0, TIMER_ONE_WAKE_ENABLE = 0, TIMER_TWO_ON = 0;
	logic HIGH_SIDE_OUTPUT, CYCLIC_WAKE;
	int n_errors = 0, compares = 0, n_cyc = 0, n_wake = 0, n = 0, p = 0;
	int on_tab[4] = '{0, ON_0P1_US, ON_0P3_US, ON_1P0_US};
	int ft_tab[2] = '{FILT_SHORT_US, FILT_LONG_US};
	localparam logic [31:0] A_FILT = 32'({FILT_IDX, 2'b00});
	localparam logic [31:0] A_TMR = 32'({TMR_IDX, 2'b00});
	localparam logic [31:0] A_UNM = 32'h0000_0040;

	// ==========================================================
	// Design and far side
	wfct_top #(.TICK_CYC(1)) u_dut (.MCLK(MCLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SOFT_RESET(SOFT_RESET),
		.RESTART_ENTRY(RESTART_ENTRY), .RESTART_MODE(RESTART_MODE), .HS_CLEARED(HS_CLEARED),
		.TIMER_ONE_ASSIGNED(TIMER_ONE_ASSIGNED), .TIMER_ONE_WAKE_ENABLE(TIMER_ONE_WAKE_ENABLE),
		.TIMER_TWO_ON(TIMER_TWO_ON), .WAKE_PIN(WAKE_PIN), .WAKE_LEVEL(WAKE_LEVEL),
		.WAKE_EVENT(WAKE_EVENT), .HIGH_SIDE_OUTPUT(HIGH_SIDE_OUTPUT), .CYCLIC_WAKE(CYCLIC_WAKE));
	wfct_switch_model u_sw (.hs_out(HIGH_SIDE_OUTPUT), .hs_fed(sw_fed), .closed(sw_closed),
		.pin(WAKE_PIN));

	// Clock, 25 ns period
	initial begin
		forever #12.5 MCLK = ~MCLK;
	end

	// ==========================================================
	// Tasks
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// One single AHB-Lite transfer; the request holds until hready is sampled high
	task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
		@(posedge MCLK);
		HSEL <= 1'b1;
		HADDR <= addr;
		HWRITE <= wr;
		HTRANS <= HTRANS_NONSEQ;
		@(posedge MCLK);
		while (HREADYOUT !== 1'b1) @(posedge MCLK);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= wd;
		@(posedge MCLK);
		while (HREADYOUT !== 1'b1) @(posedge MCLK);
		rd = HRDATA;
	endtask : bus

	task automatic wr(input logic [31:0] addr, input logic [31:0] d);
		bus(1'b1, addr, d);
	endtask : wr

	task automatic rdchk(input string name, input logic [31:0] addr, input logic [31:0] exp);
		bus(1'b0, addr, 32'h0000_0000);
		chk(name, exp, rd);
		chk("hresp", 32'(HRESP_OKAY), 32'(HRESP));
	endtask : rdchk

	task automatic idle(input int k);
		repeat (k) @(negedge MCLK);
	endtask : idle

	// Counts cycles until a wake level (0..2) or the switch output (3) shows v
	task automatic wait_on(input int which, input logic v);
		logic s;
		n = 0;
		do begin
			@(negedge MCLK);
			n++;
			s = (which == 3) ? HIGH_SIDE_OUTPUT : WAKE_LEVEL[which];
		end while (s !== v && n < 30000);
	endtask : wait_on

	// Cycle count for the hang guard, and cyclic wake pulses
	always @(posedge MCLK) begin
		n_cyc++;
		if (CYCLIC_WAKE === 1'b1) n_wake++;
		if (n_cyc == 80000) begin
			n_errors++;
			$display("[ERR] run length expected finish seen hang");
			end_sim();
		end
	end

	// ==========================================================
	// Tests
	initial begin
		repeat (8) @(posedge MCLK);
		RST <= 1'b0;
		rdchk("filt_reset", A_FILT, 32'h0000_0000);
		rdchk("tmr_reset", A_TMR, 32'h0000_0000);
		rdchk("unmapped", A_UNM, 32'h0000_0000);
		wr(A_FILT, 32'hFFFF_FFFF);
		rdchk("filt_rsvd", A_FILT, 32'h0000_003F);
		wr(A_TMR, 32'hFFFF_FFFF);
		rdchk("tmr_rsvd", A_TMR, 32'h0000_0077);
		wr(A_FILT, 32'h0000_0024);
		rdchk("filt_fields", A_FILT, 32'h0000_0024);
		$display("test registers done");
		// Restart keeps filter codes, soft reset clears them
		@(posedge MCLK);
		RESTART_ENTRY <= 1'b1;
		@(posedge MCLK);
		RESTART_ENTRY <= 1'b0;
		rdchk("filt_restart", A_FILT, 32'h0000_0024);
		rdchk("tmr_restart", A_TMR, 32'h0000_0000);
		@(posedge MCLK);
		SOFT_RESET <= 1'b1;
		@(posedge MCLK);
		SOFT_RESET <= 1'b0;
		rdchk("filt_soft", A_FILT, 32'h0000_0000);
		// Switch clear in restart: timer cleared only with a cyclic filter
		for (int c = 0; c < 2; c++) begin
			wr(A_FILT, (c == 0) ? 32'h0000_0002 : 32'h0000_0000);
			wr(A_TMR, 32'h0000_0011);
			@(posedge MCLK);
			RESTART_MODE <= 1'b1;
			HS_CLEARED <= 1'b1;
			@(posedge MCLK);
			HS_CLEARED <= 1'b0;
			RESTART_MODE <= 1'b0;
			rdchk("tmr_hs_clear", A_TMR, (c == 0) ? 32'h0000_0000 : 32'h0000_0011);
		end
		$display("test resets done");
		// Unassigned timer stays quiet, assignment starts it
		idle(300);
		chk("unassigned", 1'b0, HIGH_SIDE_OUTPUT);
		@(posedge MCLK);
		TIMER_ONE_ASSIGNED <= 1'b1;
		wait_on(3, 1'b1);
		chk("auto_start", 1'b1, n <= 4);
		wait_on(3, 1'b0);
		chk("auto_on_time", ON_0P1_US, n);
		for (int c = 1; c <= 3; c++) begin
			wr(A_TMR, 32'h0000_0000);
			idle(4);
			chk("stop_low", 1'b0, HIGH_SIDE_OUTPUT);
			wr(A_TMR, 32'(c) << TMR_ON_LSB);
			wait_on(3, 1'b1);
			wait_on(3, 1'b0);
			chk("on_time", on_tab[c], n);
		end
		$display("test on-time done");
		// Cyclic sampling on timer one, cyclic wake enabled alongside
		wr(A_FILT, 32'h0000_0002);
		@(posedge MCLK);
		sw_fed <= 3'b001;
		sw_closed <= 3'b001;
		TIMER_ONE_WAKE_ENABLE <= 1'b1;
		for (int c = 0; c < 2; c++) begin
			wr(A_TMR, 32'h0000_0000);
			wr(A_TMR, 32'h0000_0010 | 32'(c));
			wait_on(3, 1'b1);
			if (c == 0) chk("cyc_hold", 1'b0, WAKE_LEVEL[0]);
			wait_on(3, 1'b0);
			p = n;
			n_wake = 0;
			idle(4);
			if (c == 0) chk("cyc_sample", 1'b1, WAKE_LEVEL[0]);
			wait_on(3, 1'b1);
			chk("period", (c == 0) ? PER_10_MS * MS_US : PER_20_MS * MS_US, p + n + 4);
			idle(4);
			chk("cyc_wake", (c == 0) ? 1 : 0, n_wake);
			@(posedge MCLK);
			TIMER_ONE_WAKE_ENABLE <= 1'b0;
		end
		wr(A_TMR, 32'h0000_0060);
		idle(300);
		chk("stop_high", 1'b1, HIGH_SIDE_OUTPUT);
		wr(A_TMR, 32'h0000_0070);
		idle(4);
		chk("on_reserved", 1'b0, HIGH_SIDE_OUTPUT);
		rdchk("tmr_fields", A_TMR, 32'h0000_0070);
		wr(A_TMR, 32'h0000_0017);
		idle(4);
		chk("per_reserved", 1'b0, HIGH_SIDE_OUTPUT);
		$display("test period done");
		// Timer two sampling on input three
		wr(A_FILT, 32'h0000_0030);
		@(posedge MCLK);
		sw_fed <= 3'b000;
		sw_closed <= 3'b100;
		TIMER_TWO_ON <= 1'b1;
		idle(40);
		chk("t2_hold", 1'b0, WAKE_LEVEL[2]);
		@(posedge MCLK);
		TIMER_TWO_ON <= 1'b0;
		idle(4);
		chk("t2_sample", 1'b1, WAKE_LEVEL[2]);
		// Static filters, then a glitch shorter than the long filter
		for (int c = 0; c < 2; c++) begin
			wr(A_FILT, 32'(c));
			wait_on(0, 1'b0);
			@(posedge MCLK);
			sw_closed[0] <= 1'b1;
			wait_on(0, 1'b1);
			chk("static_time", 1'b1, n >= ft_tab[c] && n <= ft_tab[c] + 6);
			chk("static_event", 1'b1, WAKE_EVENT[0]);
			@(posedge MCLK);
			sw_closed[0] <= 1'b0;
		end
		wait_on(0, 1'b0);
		@(posedge MCLK);
		sw_closed[0] <= 1'b1;
		idle(30);
		@(posedge MCLK);
		sw_closed[0] <= 1'b0;
		idle(100);
		chk("glitch", 1'b0, WAKE_LEVEL[0]);
		$display("test filters done");
		end_sim();
	end
endmodule : wake_filter_cyclic_timer_bench
